// >>> include/gio_pkg.sv
// package for the general digital i/o port: register map, field layout, reset values
package gio_pkg;

    // ------------------------------------------------------------
    // widths and map
    // ------------------------------------------------------------
    localparam int GIO_PINS = 8;
    localparam int GIO_AW = 2;
    localparam logic [GIO_AW-1:0] ADDR_INPUT_SAMPLE = 2'h0;
    localparam logic [GIO_AW-1:0] ADDR_DIRECTION = 2'h1;
    localparam logic [GIO_AW-1:0] ADDR_OUTPUT_LATCH = 2'h2;
    localparam logic [GIO_AW-1:0] ADDR_MCU_CONTROL = 2'h3;

    // ------------------------------------------------------------
    // mcu control layout and reset values
    // ------------------------------------------------------------
    localparam int PUD_BIT = 4;
    localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MCU_CONTROL_WMASK = 8'h93;
    localparam logic [7:0] PORT_RESET = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [GIO_AW-1:0] addr;
        logic [7:0] wdata;
    } gio_req_t;

    typedef struct packed {
        logic [GIO_PINS-1:0] drive_out;
        logic [GIO_PINS-1:0] drive_oe;
        logic [GIO_PINS-1:0] pullup_en;
    } gio_pad_t;

endpackage : gio_pkg

// >>> core/gio_port.sv
// general digital i/o port: registers, pad control and input synchroniser
// Operation
// - direction bit one makes the pin output, zero makes it input
// - input pin with latch one has pull-up; latch zero or output removes it
// - reset tri-states every pin asynchronously, even without clock
// - output pin drives the latch value, with no pull-up
// - writing one to input sample register toggles the latch bit
// - three locations per port: latch, direction read/write, input sample read, where a write toggles latch bits
// - global pull-up disable keeps every pull-up off
// - pull-up only when direction zero, latch one, global disable zero
// - after reset direction and latch are zero: input, no pull-up
// - single bits change without disturbing other pins of the port
// - input sample follows the pad whatever the direction, through two stages
// - first stage captures on falling clock, second loads on rising edge
// - written pin value reads back one clock later; software inserts a nop
// - alternate functions on some pins leave other pins as general i/o
// - global pull-up disable is bit 4 of mcu control, reset zero
`timescale 1ns/100ps
`default_nettype none

module gio_port
    import gio_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register access
    input wire gio_pkg::gio_req_t req,
    output logic [7:0] rdata,
    // pads
    input wire logic [gio_pkg::GIO_PINS-1:0] pad_in,
    output gio_pkg::gio_pad_t pad,
    // alternate function ownership, one bit per pin
    input wire logic [gio_pkg::GIO_PINS-1:0] alt_own,
    input wire logic [gio_pkg::GIO_PINS-1:0] alt_out,
    input wire logic [gio_pkg::GIO_PINS-1:0] alt_oe
);
    import gio_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] direction_register;
    logic [7:0] output_latch_register;
    logic [7:0] input_sample_register;
    logic [7:0] mcu_control;
    logic [7:0] sync_latch;
    logic [7:0] next_direction_register;
    logic [7:0] next_output_latch_register;
    logic [7:0] next_mcu_control;
    logic [7:0] next_rdata;
    gio_pad_t next_pad;
    logic wr_direction;
    logic wr_output_latch;
    logic wr_input_sample;
    logic wr_mcu_control;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // write strobe aimed at one location of the map
    function automatic logic hit(input gio_req_t r, input logic [GIO_AW-1:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    // per pin: alternate value where the pin is owned, port value elsewhere
    function automatic logic [GIO_PINS-1:0] pick(
        input logic [GIO_PINS-1:0] port_val,
        input logic [GIO_PINS-1:0] alt_val,
        input logic [GIO_PINS-1:0] own
    );
        pick = (port_val & ~own) | (alt_val & own);
    endfunction : pick

    // pull-up needs input, latch one and the global disable clear
    function automatic logic [GIO_PINS-1:0] pull_mask(
        input logic [GIO_PINS-1:0] dir,
        input logic [GIO_PINS-1:0] latch,
        input logic [7:0] ctrl
    );
        pull_mask = ~dir & latch & {GIO_PINS{~ctrl[PUD_BIT]}};
    endfunction : pull_mask

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_comb
    begin
        wr_direction = hit(req, ADDR_DIRECTION);
        wr_output_latch = hit(req, ADDR_OUTPUT_LATCH);
        wr_input_sample = hit(req, ADDR_INPUT_SAMPLE);
        wr_mcu_control = hit(req, ADDR_MCU_CONTROL);
    end

    always_comb
    begin
        next_direction_register = direction_register;
        next_output_latch_register = output_latch_register;
        next_mcu_control = mcu_control;
        // bit instructions arrive as whole-byte writes of a read value, so each pin stays put
        if (wr_direction)
        begin
            next_direction_register = req.wdata;
        end
        if (wr_output_latch)
        begin
            next_output_latch_register = req.wdata;
        end
        // the sample location stores nothing; each one written flips its latch bit
        if (wr_input_sample)
        begin
            next_output_latch_register = output_latch_register ^ req.wdata;
        end
        // reserved bits masked so they always read zero
        if (wr_mcu_control)
        begin
            next_mcu_control = req.wdata & MCU_CONTROL_WMASK;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            direction_register <= PORT_RESET;
            output_latch_register <= PORT_RESET;
            mcu_control <= MCU_CONTROL_RESET;
        end
        else
        begin
            direction_register <= next_direction_register;
            output_latch_register <= next_output_latch_register;
            mcu_control <= next_mcu_control;
        end
    end

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    // falling-edge stage stands in for the level latch; pad to register is half to one and a half periods
    always_ff @(negedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_latch <= PORT_RESET;
        end
        else
        begin
            sync_latch <= pad_in;
        end
    end

    // a pin driven at one edge shows here one edge later, hence the nop before a read
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            input_sample_register <= PORT_RESET;
        end
        else
        begin
            input_sample_register <= sync_latch;
        end
    end

    // ------------------------------------------------------------
    // pad control
    // ------------------------------------------------------------
    // built from next values so the pins move at the very edge that takes the write
    always_comb
    begin
        next_pad.drive_oe = next_direction_register;
        next_pad.drive_out = next_output_latch_register;
        next_pad.pullup_en = pull_mask(next_direction_register, next_output_latch_register, next_mcu_control);
        // owned pins follow their alternate function, the rest stay general i/o
        next_pad.drive_oe = pick(next_pad.drive_oe, alt_oe, alt_own);
        next_pad.drive_out = pick(next_pad.drive_out, alt_out, alt_own);
        // an alternate function has no pull-up input of its own, so owned pins get no pull-up at all
        next_pad.pullup_en = next_pad.pullup_en & ~alt_own;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pad <= '0;
        end
        else
        begin
            pad <= next_pad;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // reads are always live: the location presented at one edge answers at the next
    always_comb
    begin
        case (req.addr)
            ADDR_INPUT_SAMPLE: next_rdata = input_sample_register;
            ADDR_DIRECTION: next_rdata = direction_register;
            ADDR_OUTPUT_LATCH: next_rdata = output_latch_register;
            ADDR_MCU_CONTROL: next_rdata = mcu_control;
            default: next_rdata = PORT_RESET;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata <= PORT_RESET;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

endmodule : gio_port

`default_nettype wire

// >>> dv/gio_port_asserts.sv
// checker for the i/o port
`timescale 1ns/100ps
`default_nettype none
module gio_port_asserts
    import gio_pkg::*;
(
    // watched ports
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire gio_pkg::gio_req_t req,
    input wire logic [7:0] rdata,
    input wire gio_pkg::gio_pad_t pad,
    input wire logic [7:0] alt_own,
    input wire logic [7:0] alt_oe
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    wire gpio = alt_own == '0;
    wire wr_dir = req.wr && req.addr == ADDR_DIRECTION;
    wire wr_in = req.wr && req.addr == ADDR_INPUT_SAMPLE;
    rst_tristate_a: assert property (disable iff (1'b0) !reset_n |-> pad == '0)
        else $error("pads active in reset");
    dir_write_a: assert property (gpio && wr_dir |=> pad.drive_oe == $past(req.wdata))
        else $error("direction not applied");
    out_nopull_a: assert property (gpio |-> (pad.pullup_en & pad.drive_oe) == '0)
        else $error("pull-up on output");
    toggle_latch_a: assert property (gpio && wr_in && pad.drive_oe == '1 |=>
        pad.drive_out == ($past(pad.drive_out) ^ $past(req.wdata))) else $error("toggle wrong");
    pud_off_a: assert property (req.wr && req.addr == ADDR_MCU_CONTROL && req.wdata[PUD_BIT] |=>
        pad.pullup_en == '0) else $error("pull-up despite disable");
    pull_enable_a: assert property (gpio && req.wr && req.addr == ADDR_OUTPUT_LATCH &&
        pad.drive_oe == '0 && pad.pullup_en != '0 |=> pad.pullup_en == $past(req.wdata)) else $error("pull-up wrong");
    dir_readback_a: assert property (wr_dir ##1 req.addr == ADDR_DIRECTION |=>
        rdata == $past(req.wdata, 2)) else $error("direction readback");
    alt_pass_a: assert property (alt_own != '0 |=>
        ((pad.drive_oe ^ $past(alt_oe)) & $past(alt_own)) == '0) else $error("alternate enable");
    cover property (wr_dir ##1 req.addr == ADDR_DIRECTION);
    cover property (wr_in);
    cover property (alt_own != '0);
endmodule : gio_port_asserts
bind gio_port gio_port_asserts i_chk (.sys_clk(sys_clk), .reset_n(reset_n), .req(req), .rdata(rdata),
    .pad(pad), .alt_own(alt_own), .alt_oe(alt_oe));
`default_nettype wire

// >>> dv/gio_pads.sv
// pad model: external drivers, pull-ups, floating lines
`timescale 1ns/100ps
`default_nettype none
module gio_pads
    import gio_pkg::*;
(
    // pins
    input wire logic sys_clk,
    input wire gio_pkg::gio_pad_t pad,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    // a floating line wanders, so a stale level is never read back
    logic [7:0] flt = '0;
    always_ff @(posedge sys_clk) flt <= ~flt;
    assign pad_in = pad.drive_oe & pad.drive_out | ~pad.drive_oe & (ext_en & ext_val | ~ext_en & (pad.pullup_en | flt));
endmodule : gio_pads
`default_nettype wire

// >>> dv/tb.sv
// testbench for the i/o port
`timescale 1ns/100ps
`default_nettype none
module tb;
    import gio_pkg::*;
    logic sys_clk = 0;
    logic reset_n = 0;
    gio_req_t req = '0;
    logic [7:0] rdata, pad_in, alt_own = '0, alt_out = '0, alt_oe = '0, ext_en = '0, ext_val = '0;
    gio_pad_t pad;
    int failures = 0;
    int compares = 0;
    always #2.5 sys_clk = ~sys_clk;
    gio_port i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .req(req), .rdata(rdata), .pad_in(pad_in),
        .pad(pad), .alt_own(alt_own), .alt_out(alt_out), .alt_oe(alt_oe));
    gio_pads i_pads (.sys_clk(sys_clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        req.addr <= a;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(24'(rdata), 24'(e), "rdata");
    endtask : rd
    // undriven pins still carry the latch value on drive_out, so it is masked by the enable
    task automatic pads(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu);
        @(negedge sys_clk);
        chk({pad.drive_out & pad.drive_oe, pad.drive_oe, pad.pullup_en}, {o, oe, pu}, "pad");
    endtask : pads
    task automatic t_reset;
        pads(8'h00, 8'h00, 8'h00);
        rd(ADDR_MCU_CONTROL, 8'h00);
        rd(ADDR_OUTPUT_LATCH, 8'h00);
    endtask : t_reset
    task automatic t_out;
        wr(ADDR_OUTPUT_LATCH, 8'ha5);
        pads(8'h00, 8'h00, 8'ha5);
        wr(ADDR_DIRECTION, 8'hff);
        rd(ADDR_INPUT_SAMPLE, 8'ha5);
        pads(8'hff, 8'ha5, 8'h00);
        wr(ADDR_INPUT_SAMPLE, 8'h0f);
        rd(ADDR_OUTPUT_LATCH, 8'haa);
    endtask : t_out
    // pins 7 and 5 go pull-up to output low via high-z, then output low to output high
    task automatic t_switch;
        wr(ADDR_DIRECTION, 8'h00);
        pads(8'h00, 8'h00, 8'haa);
        wr(ADDR_OUTPUT_LATCH, 8'h0a);
        pads(8'h00, 8'h00, 8'h0a);
        wr(ADDR_DIRECTION, 8'ha0);
        pads(8'ha0, 8'h00, 8'h0a);
        wr(ADDR_OUTPUT_LATCH, 8'haa);
        pads(8'ha0, 8'ha0, 8'h0a);
    endtask : t_switch
    task automatic t_pull;
        wr(ADDR_DIRECTION, 8'h00);
        pads(8'h00, 8'h00, 8'haa);
        @(posedge sys_clk);
        ext_en <= 8'hff;
        ext_val <= 8'h0f;
        rd(ADDR_INPUT_SAMPLE, 8'h0f);
        wr(ADDR_DIRECTION, 8'h08);
        wr(ADDR_MCU_CONTROL, 8'hff);
        rd(ADDR_MCU_CONTROL, 8'h93);
        pads(8'h08, 8'h08, 8'h00);
        wr(ADDR_INPUT_SAMPLE, 8'h01);
        rd(ADDR_OUTPUT_LATCH, 8'hab);
        wr(ADDR_MCU_CONTROL, 8'h00);
        alt_own <= 8'h04;
        alt_oe <= 8'h04;
        alt_out <= 8'h04;
        @(posedge sys_clk);
        pads(8'h0c, 8'h0c, 8'ha3);
    endtask : t_pull
    task automatic t_async;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        #1 chk(pad, 24'h00_0000, "pad");
        @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask : t_async
    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_out();
        t_switch();
        t_pull();
        t_async();
        t_reset();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
